// file: common/pmp_defines.svh
`ifndef PMP_DEFINES_SVH
`define PMP_DEFINES_SVH

`define PMP_ADDR_W      12
`define PMP_CTRL_OFFS   12'h000
`define PMP_STAT_OFFS   12'h004
`define PMP_CTRL_ROMSEL 0
`define PMP_CTRL_IDLE   1
`define PMP_CTRL_SLEEP  2
`define PMP_CTRL_RST    3'h0
`define PMP_STAT_IRPOL  0
`define PMP_STAT_CLKEXT 1
`define PMP_STAT_A2FLT  2
`define PMP_STAT_DONE   3
`define PMP_STAT_XTAL   4

`endif

// file: common/pmp_pkg.sv
`include "pmp_defines.svh"

package pmp_pkg;

   typedef struct packed {
      logic                   psel;
      logic                   penable;
      logic                   pwrite;
      logic [`PMP_ADDR_W-1:0] paddr;
      logic [31:0]            pwdata;
   } pmp_apb_req_t;

   typedef struct packed {
      logic        pready;
      logic        pslverr;
      logic [31:0] prdata;
   } pmp_apb_rsp_t;

   typedef struct packed {
      logic romsel;
      logic idle;
      logic sleep;
   } pmp_ctrl_t;

   typedef struct packed {
      logic xtal;
      logic done;
      logic a2_float;
      logic clk_ext;
      logic ir_pol;
   } pmp_stat_t;

   typedef struct packed {
      logic        first;
      logic        ir_pol;
      logic        clk_strap;
      logic        xtal;
      logic        pu3;
      logic        pd2;
      logic [11:0] a_hi;
      logic        a3;
      logic        a2;
      logic        oe3_n;
      logic        oe2_n;
      logic [7:0]  d_o;
      logic        d_oe_n;
      logic [7:0]  rdata;
   } pmp_pin_state_t;

endpackage

// file: hw/pmp_apb_regs.sv
`timescale 1ns/1ps
`include "pmp_defines.svh"

module pmp_apb_regs (
   input  wire logic                 pclk,
   input  wire logic                 presetn,
   input  wire pmp_pkg::pmp_apb_req_t req,
   output pmp_pkg::pmp_apb_rsp_t     rsp,
   input  wire pmp_pkg::pmp_stat_t   stat,
   output pmp_pkg::pmp_ctrl_t        ctrl
);

   typedef struct packed {
      pmp_pkg::pmp_apb_rsp_t rsp;
      pmp_pkg::pmp_ctrl_t    ctrl;
   } pmp_reg_state_t;

   pmp_reg_state_t q;
   pmp_reg_state_t d;

   function automatic logic hit(input logic [`PMP_ADDR_W-1:0] a,
                                input logic [`PMP_ADDR_W-1:0] o);
      hit = (a == o);
   endfunction

   // Ready is registered, so every transfer has exactly one access cycle
   always_comb begin
      d = q;
      d.rsp.pready = 1'b0;
      d.rsp.pslverr = 1'b0;
      if (req.psel && !req.penable) begin
         d.rsp.pready = 1'b1;
         d.rsp.prdata = 32'h0;
         if (hit(req.paddr, `PMP_CTRL_OFFS)) begin
            d.rsp.prdata[`PMP_CTRL_ROMSEL] = q.ctrl.romsel;
            d.rsp.prdata[`PMP_CTRL_IDLE] = q.ctrl.idle;
            d.rsp.prdata[`PMP_CTRL_SLEEP] = q.ctrl.sleep;
         end else if (hit(req.paddr, `PMP_STAT_OFFS)) begin
            d.rsp.prdata[`PMP_STAT_IRPOL] = stat.ir_pol;
            d.rsp.prdata[`PMP_STAT_CLKEXT] = stat.clk_ext;
            d.rsp.prdata[`PMP_STAT_A2FLT] = stat.a2_float;
            d.rsp.prdata[`PMP_STAT_DONE] = stat.done;
            d.rsp.prdata[`PMP_STAT_XTAL] = stat.xtal;
         end else begin
            d.rsp.pslverr = 1'b1;
         end
      end
      if (req.psel && req.penable && q.rsp.pready && req.pwrite
          && hit(req.paddr, `PMP_CTRL_OFFS)) begin
         d.ctrl.romsel = req.pwdata[`PMP_CTRL_ROMSEL];
         d.ctrl.idle = req.pwdata[`PMP_CTRL_IDLE];
         d.ctrl.sleep = req.pwdata[`PMP_CTRL_SLEEP];
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         q.rsp <= '0;
         q.ctrl <= `PMP_CTRL_RST;
      end else begin
         q <= d;
      end
   end

   assign rsp = q.rsp;
   assign ctrl = q.ctrl;

endmodule // pmp_apb_regs

// file: hw/pmp_port.sv
`timescale 1ns/1ps

module pmp_port (
   input  wire logic                  pclk,
   input  wire logic                  presetn,

   input  wire pmp_pkg::pmp_apb_req_t apb_req,
   output pmp_pkg::pmp_apb_rsp_t      apb_rsp,

   input  wire logic [15:0]           cpu_addr,
   input  wire logic [7:0]            cpu_wdata,
   input  wire logic                  cpu_wr,
   output logic [7:0]                 cpu_rdata,
   input  wire logic                  second_ext_interrupt,

   output logic [11:0]                prog_addr_high,
   output logic                       prog_addr_bit3_o,
   input  wire logic                  prog_addr_bit3_i,
   output logic                       prog_addr_bit3_oe_n,
   output logic                       prog_addr_bit2_o,
   input  wire logic                  prog_addr_bit2_i,
   output logic                       prog_addr_bit2_oe_n,
   output logic                       addr3_pullup_en,
   output logic                       addr2_pulldown_en,

   output logic [7:0]                 prog_data_bus_o,
   input  wire logic [7:0]            prog_data_bus_i,
   output logic                       prog_data_bus_oe_n,

   output logic                       ir_led_polarity_strap,
   output logic                       clock_drive_strap,
   output logic                       crystal_mode
);

   pmp_pkg::pmp_pin_state_t q;
   pmp_pkg::pmp_pin_state_t d;
   pmp_pkg::pmp_ctrl_t      ctrl;
   pmp_pkg::pmp_stat_t      stat;
   logic                    ext_mem;
   logic                    float2;

   pmp_apb_regs u_regs (
      .pclk    (pclk),
      .presetn (presetn),
      .req     (apb_req),
      .rsp     (apb_rsp),
      .stat    (stat),
      .ctrl    (ctrl)
   );

   assign ext_mem = !ctrl.romsel;
   // Bit2 may only float when an external clock drives the chip, never a crystal
   function automatic logic idle_float(input logic strap,
                                       input logic idle,
                                       input logic irq,
                                       input logic sleep);
      idle_float = strap && idle && !irq && sleep;
   endfunction

   assign float2 = idle_float(q.clk_strap, ctrl.idle, second_ext_interrupt, ctrl.sleep);

   assign stat.ir_pol = q.ir_pol;
   assign stat.clk_ext = q.clk_strap;
   assign stat.a2_float = q.oe2_n && !q.first;
   assign stat.done = !q.first;
   assign stat.xtal = q.xtal;

   // Reset leaves pins undriven with pulls on; the first edge after release samples them
   always_comb begin
      d = q;
      if (q.first) begin
         d.first = 1'b0;
         d.ir_pol = prog_addr_bit3_i;
         d.pu3 = 1'b0;
         d.oe3_n = 1'b0;
         d.clk_strap = prog_addr_bit2_i;
         d.xtal = !prog_addr_bit2_i;
         d.pd2 = 1'b0;
         d.oe2_n = 1'b0;
      end else begin
         d.a_hi = cpu_addr[15:4];
         d.a3 = cpu_addr[3];
         d.a2 = cpu_addr[2];
         d.oe3_n = 1'b0;
         // Crystal mode never floats bit2 because float2 needs the strap set
         d.oe2_n = float2;
         d.d_o = cpu_wdata;
         d.d_oe_n = !(ext_mem && cpu_wr);
         if (ext_mem && !cpu_wr) begin
            d.rdata = prog_data_bus_i;
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         q <= '0;
         q.first <= 1'b1;
         q.pu3 <= 1'b1;
         q.pd2 <= 1'b1;
         q.oe3_n <= 1'b1;
         q.oe2_n <= 1'b1;
         q.d_oe_n <= 1'b1;
      end else begin
         q <= d;
      end
   end

   assign cpu_rdata = q.rdata;
   assign prog_addr_high = q.a_hi;
   assign prog_addr_bit3_o = q.a3;
   assign prog_addr_bit3_oe_n = q.oe3_n;
   assign prog_addr_bit2_o = q.a2;
   assign prog_addr_bit2_oe_n = q.oe2_n;
   assign addr3_pullup_en = q.pu3;
   assign addr2_pulldown_en = q.pd2;
   assign prog_data_bus_o = q.d_o;
   assign prog_data_bus_oe_n = q.d_oe_n;
   assign ir_led_polarity_strap = q.ir_pol;
   assign clock_drive_strap = q.clk_strap;
   assign crystal_mode = q.xtal;

   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);

   a_ext_data_drive:
   assert property (!q.first && !ctrl.romsel && cpu_wr
                    |=> !prog_data_bus_oe_n && prog_data_bus_o == $past(cpu_wdata))
      else $error("data bus not driven for external write");

   a_int_rom_quiet:
   assert property (!q.first && ctrl.romsel |=> prog_data_bus_oe_n)
      else $error("data bus driven while internal rom selected");

   a_addr_follow:
   assert property (!q.first
                    |=> prog_addr_high == $past(cpu_addr[15:4])
                        && prog_addr_bit3_o == $past(cpu_addr[3]))
      else $error("address pins do not follow cpu address");

   a_strap3_sense:
   assert property (q.first |-> addr3_pullup_en && prog_addr_bit3_oe_n)
      else $error("bit3 pin not sensing during reset");

   // The release edge still samples reset low, so latch checks start one edge later
   a_strap3_latch:
   assert property (q.first && presetn |=> ir_led_polarity_strap == $past(prog_addr_bit3_i)
                    && !addr3_pullup_en && !prog_addr_bit3_oe_n)
      else $error("polarity strap not latched on release");

   a_strap2_sense:
   assert property (q.first |-> addr2_pulldown_en && prog_addr_bit2_oe_n)
      else $error("bit2 pin not sensing during reset");

   a_strap2_latch:
   assert property (q.first && presetn |=> clock_drive_strap == $past(prog_addr_bit2_i)
                    && !addr2_pulldown_en)
      else $error("clock strap not latched on release");

   a_clk_decode:
   assert property (!q.first |-> crystal_mode != clock_drive_strap)
      else $error("clock mode decode wrong");

   a_addr2_float:
   assert property (!q.first && clock_drive_strap && ctrl.idle
                    && !second_ext_interrupt && ctrl.sleep |=> prog_addr_bit2_oe_n)
      else $error("bit2 not floated in idle sleep");

   a_addr2_drive:
   assert property (!q.first && !clock_drive_strap |=> !prog_addr_bit2_oe_n)
      else $error("bit2 floated in crystal mode");

   a_strap_hold:
   assert property (!q.first |=> $stable(ir_led_polarity_strap)
                    && $stable(clock_drive_strap) && !q.first)
      else $error("strap changed after capture");

   a_capture_once:
   assert property (q.first && presetn |=> !q.first)
      else $error("strap capture did not finish");

   a_capture_quiet:
   assert property (q.first |-> prog_data_bus_oe_n)
      else $error("data bus driven before capture");

   a_bit3_driven:
   assert property (!q.first |-> !prog_addr_bit3_oe_n)
      else $error("bit3 pin not driven after capture");

   a_pulls_off:
   assert property (!q.first |-> !addr3_pullup_en && !addr2_pulldown_en)
      else $error("strap pulls left on after capture");

   a_bit2_follow:
   assert property (!q.first && !clock_drive_strap
                    |=> prog_addr_bit2_o == $past(cpu_addr[2]))
      else $error("bit2 pin does not follow cpu address");

   a_crystal_drive:
   assert property (!q.first && !clock_drive_strap |-> !prog_addr_bit2_oe_n)
      else $error("bit2 undriven in crystal mode");

   a_float_release:
   assert property (!q.first && !(ctrl.idle && !second_ext_interrupt && ctrl.sleep)
                    |=> !prog_addr_bit2_oe_n)
      else $error("bit2 floated outside idle sleep");

   a_rom_read_hold:
   assert property (!q.first && ctrl.romsel |=> $stable(cpu_rdata))
      else $error("read data taken while internal rom selected");

   c_ext_clock_boot:
   cover property (q.first ##1 clock_drive_strap);

   c_bit2_float:
   cover property (!q.first ##1 prog_addr_bit2_oe_n ##1 !prog_addr_bit2_oe_n);

   c_ext_write:
   cover property (!q.first && !ctrl.romsel && cpu_wr ##1 !prog_data_bus_oe_n);

   c_rom_select:
   cover property (!q.first && ctrl.romsel && cpu_wr ##1 prog_data_bus_oe_n);

   c_strap_release:
   cover property (q.first && presetn ##1 !q.first && ir_led_polarity_strap);

endmodule // pmp_port

// file: tb/pmp_mem_model.sv
`timescale 1ns/1ps

module pmp_mem_model (
   input  wire logic        pclk,
   input  wire logic [11:0] addr_high,
   input  wire logic        a3_o,
   input  wire logic        a3_oe_n,
   input  wire logic        a2_o,
   input  wire logic        a2_oe_n,
   input  wire logic [7:0]  data_o,
   input  wire logic        data_oe_n,
   input  wire logic        ir_strap,
   input  wire logic        clk_strap,
   output logic             a3_i,
   output logic             a2_i,
   output logic [7:0]       data_i
);
   logic [7:0] mem_q [16];
   logic [3:0] idx;
   // Board strap resistors win whenever the device lets a pin go
   assign a3_i   = a3_oe_n ? ir_strap : a3_o;
   assign a2_i   = a2_oe_n ? clk_strap : a2_o;
   // Few address bits only: a small array keeps the model cheap
   assign idx    = {addr_high[1:0], a3_o, a2_o};
   assign data_i = data_oe_n ? mem_q[idx] : data_o;
   always_ff @(posedge pclk) begin
      if (!data_oe_n) begin
         mem_q[idx] <= data_o;
      end
   end
endmodule // pmp_mem_model

// file: tb/program_memory_port_straps_bench.sv
`timescale 1ns/1ps
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin bad_count++; \
   $display("unexpected %0t got %h exp %h", $time, g, e); end end

module program_memory_port_straps_bench;
   logic                  pclk = 0, presetn = 0, cpu_wr = 0, sei = 0, ir_s = 0, clk_s = 0;
   logic [15:0]           cpu_addr = 16'h0000;
   logic [7:0]            cpu_wdata = 8'h00, cpu_rdata, d_o, d_i;
   logic [11:0]           a_hi;
   logic                  a3_o, a3_i, a3_oe_n, a2_o, a2_i, a2_oe_n, pu3, pd2, d_oe_n;
   logic                  irp, cks, xtal, e;
   logic [31:0]           r;
   pmp_pkg::pmp_apb_req_t req = '0;
   pmp_pkg::pmp_apb_rsp_t rsp;
   int                    bad_count = 0, compares = 0;

   always #5 pclk = ~pclk;

   pmp_port i_pmp_port (.pclk(pclk), .presetn(presetn), .apb_req(req), .apb_rsp(rsp),
      .cpu_addr(cpu_addr), .cpu_wdata(cpu_wdata), .cpu_wr(cpu_wr), .cpu_rdata(cpu_rdata),
      .second_ext_interrupt(sei), .prog_addr_high(a_hi), .prog_addr_bit3_o(a3_o),
      .prog_addr_bit3_i(a3_i), .prog_addr_bit3_oe_n(a3_oe_n), .prog_addr_bit2_o(a2_o),
      .prog_addr_bit2_i(a2_i), .prog_addr_bit2_oe_n(a2_oe_n), .addr3_pullup_en(pu3),
      .addr2_pulldown_en(pd2), .prog_data_bus_o(d_o), .prog_data_bus_i(d_i),
      .prog_data_bus_oe_n(d_oe_n), .ir_led_polarity_strap(irp), .clock_drive_strap(cks),
      .crystal_mode(xtal));

   pmp_mem_model i_pmp_mem_model (.pclk(pclk), .addr_high(a_hi), .a3_o(a3_o),
      .a3_oe_n(a3_oe_n), .a2_o(a2_o), .a2_oe_n(a2_oe_n), .data_o(d_o), .data_oe_n(d_oe_n),
      .ir_strap(ir_s), .clk_strap(clk_s), .a3_i(a3_i), .a2_i(a2_i), .data_i(d_i));

   task automatic cyc(input int n);
      repeat (n) @(posedge pclk);
      #1;
   endtask

   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge pclk);
      req.psel <= 1'b1; req.pwrite <= w; req.paddr <= a; req.pwdata <= d;
      @(posedge pclk);
      req.penable <= 1'b1;
      do begin @(posedge pclk); n++; end while (rsp.pready !== 1'b1 && n < 50);
      if (n == 50) bad_count++;
      r = rsp.prdata;
      e = rsp.pslverr;
      req.psel <= 1'b0;
      req.penable <= 1'b0;
   endtask

   task automatic strap_reset(input logic i, input logic c);
      @(posedge pclk);
      presetn <= 1'b0; ir_s <= i; clk_s <= c;
      cyc(16);
      `CHK({pu3, pd2, a3_oe_n, a2_oe_n}, 4'hf)
      @(posedge pclk);
      presetn <= 1'b1;
      cyc(2);
      `CHK({irp, cks, xtal, pu3, pd2}, {i, c, ~c, 2'b00})
      `CHK({a3_oe_n, a2_oe_n}, 2'b00)
      // Straps moving after release must not reach the latches
      ir_s <= ~i; clk_s <= ~c;
      apb(1'b0, 12'h004, 32'h0);
      `CHK(r[4:0], {~c, 1'b1, 1'b0, c, i})
   endtask

   task automatic addr_chk(input logic [15:0] a);
      @(posedge pclk);
      cpu_addr <= a;
      cyc(2);
      `CHK({a_hi, a3_o, a2_o}, a[15:2])
   endtask

   task automatic mem_rw(input logic [7:0] d);
      @(posedge pclk);
      cpu_wr <= 1'b1; cpu_wdata <= d;
      cyc(1);
      `CHK({d_oe_n, d_o}, {1'b0, d})
      cpu_wr <= 1'b0; cpu_wdata <= ~d;
      cyc(3);
      `CHK({d_oe_n, cpu_rdata}, {1'b1, d})
   endtask

   task automatic idle_sleep(input logic c);
      strap_reset(1'b1, c);
      sei <= 1'b0;
      apb(1'b1, 12'h000, 32'h6);
      cyc(3);
      `CHK(a2_oe_n, c)
      `CHK(a3_oe_n, 1'b0)
      apb(1'b0, 12'h004, 32'h0);
      `CHK(r[2], c)
      sei <= 1'b1;
      cyc(3);
      `CHK(a2_oe_n, 1'b0)
      apb(1'b1, 12'h000, 32'h0);
   endtask

   task automatic rom_sel(input logic [7:0] held);
      apb(1'b1, 12'h000, 32'h1);
      apb(1'b0, 12'h000, 32'h0);
      `CHK(r[2:0], 3'h1)
      cpu_wr <= 1'b1;
      cpu_wdata <= ~held;
      cyc(2);
      `CHK({d_oe_n, cpu_rdata}, {1'b1, held})
      @(posedge pclk);
      cpu_wr <= 1'b0;
      apb(1'b1, 12'h000, 32'h0);
   endtask

   task automatic end_sim;
      if (bad_count == 0 && compares > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask

   initial begin
      #200000;
      bad_count++;
      end_sim;
   end

   initial begin
      strap_reset(1'b0, 1'b0);
      addr_chk(16'ha5f8);
      addr_chk(16'h5a04);
      mem_rw(8'h3c);
      mem_rw(8'hc3);
      rom_sel(8'hc3);
      apb(1'b0, 12'h010, 32'h0);
      `CHK({e, r}, {1'b1, 32'h0})
      strap_reset(1'b1, 1'b1);
      idle_sleep(1'b1);
      idle_sleep(1'b0);
      end_sim;
   end
endmodule // program_memory_port_straps_bench
